//--- rtl/uhr_field_dec.sv
// Purpose: split an instruction word into the read fields
// Assumes: word valid in the same cycle
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
module uhr_field_dec
  import uhr_pkg::*;
(
  // instruction
  input  wire logic [31:0] instr_i,
  // fields
  uhr_fields_if.dec        fld
);
  assign fld.is_op = (instr_i[OPC_HI:OPC_LO] == SPECIAL_THREE_OPCODE)
                   && (instr_i[FUNC_HI:FUNC_LO] == READ_HW_FUNC)
                   && (instr_i[ZERO_A_HI:ZERO_A_LO] == 5'h00)
                   && (instr_i[ZERO_B_HI:ZERO_B_LO] == 2'h0);
  assign fld.dest  = instr_i[DEST_HI:DEST_LO];
  assign fld.rnum  = instr_i[RNUM_HI:RNUM_LO];
  assign fld.sel   = instr_i[SEL_HI:SEL_LO];
endmodule // uhr_field_dec
`default_nettype wire

//--- rtl/uhr_fields_if.sv
// Purpose: decoded fields of one instruction word
// Assumes: filled by the decoder leaf, read by the top
// Notes:   none
`timescale 1ns/10ps
`default_nettype none
interface uhr_fields_if;
  logic       is_op;
  logic [4:0] dest;
  logic [4:0] rnum;
  logic [2:0] sel;
  modport dec (output is_op, output dest, output rnum, output sel);
  modport use_side (input is_op, input dest, input rnum, input sel);
endinterface
`default_nettype wire

//--- rtl/uhr_pkg.sv
// Purpose: constants for the user hardware register read decoder
// Assumes: 64-bit datapath, 32 gprs
// Notes:   field positions and register numbers of the read instruction
package uhr_pkg;
  localparam int          XLEN            = 64;
  localparam int          OPC_HI          = 31;
  localparam int          OPC_LO          = 26;
  localparam int          ZERO_A_HI       = 25;
  localparam int          ZERO_A_LO       = 21;
  localparam int          DEST_HI         = 20;
  localparam int          DEST_LO         = 16;
  localparam int          RNUM_HI         = 15;
  localparam int          RNUM_LO         = 11;
  localparam int          ZERO_B_HI       = 10;
  localparam int          ZERO_B_LO       = 9;
  localparam int          SEL_HI          = 8;
  localparam int          SEL_LO          = 6;
  localparam int          FUNC_HI         = 5;
  localparam int          FUNC_LO         = 0;
  localparam logic [5:0]  SPECIAL_THREE_OPCODE = 6'h1f;
  localparam logic [5:0]  READ_HW_FUNC    = 6'h3b;
  localparam logic [4:0]  HWR_CPU_INDEX   = 5'h00;
  localparam logic [4:0]  HWR_SYNC_STEP   = 5'h01;
  localparam logic [4:0]  HWR_CYCLE_COUNT = 5'h02;
  localparam logic [4:0]  HWR_CC_RES      = 5'h03;
  localparam logic [4:0]  HWR_PERF        = 5'h04;
  localparam logic [4:0]  HWR_PAIRED_ATOM = 5'h05;
  localparam logic [4:0]  HWR_THREAD_PTR  = 5'h1d;
  localparam logic [4:0]  HWR_IMPL_A      = 5'h1e;
  localparam logic [4:0]  HWR_IMPL_B      = 5'h1f;
  localparam logic [2:0]  SEL_LEGACY      = 3'h0;
  localparam int          PERF_PAIRS      = 4;
  localparam int          CPU_INDEX_W     = 10;
  localparam logic [63:0] RESET_DATA      = 64'h0;
  localparam logic [31:0] ISR_OFF         = 32'h0;
  localparam logic [31:0] IMR_OFF         = 32'h4;
  localparam int          EV_DONE         = 0;
  localparam int          EV_RSVD         = 1;
  localparam int          EV_W            = 2;
endpackage

//--- rtl/uhr_read_hw.sv
// Purpose: execute the user read of privileged hardware values
// Assumes: one instruction per valid cycle, answer one cycle later
// Notes:   small register port holds the event status and mask
//
// Overview of operation
// - decode opcode 011111, function 111011, zero bits 25..21, 10..9.
// - permitted read sign-extends the value into destination gpr.
// - read permitted when cp0 enabled or mask bit for number set.
// - not permitted or unimplemented number raises reserved exception.
// - newest revision: undefined select for the number raises reserved exception.
// - number 0 returns cpu index from exception base register.
// - number 1 returns cache sync step, zero if none needed.
// - number 2 returns the cycle counter.
// - number 3 returns cycles between counter increments.
// - number 4 returns perf control on even select, counter on odd.
// - number 5 returns paired atomic absent bit zero-extended.
// - numbers 6 to 28 reserved, reading raises reserved exception.
// - number 29 returns thread pointer when implemented.
// - numbers 30, 31 implementation values, else reserved exception.
// - first revision treats the whole instruction as reserved.
// - 64-bit values pass with 64-bit ops, otherwise sign-extended.
// - select zero keeps the legacy register numbering.
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module uhr_read_hw
  import uhr_pkg::*;
(
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  // instruction issue
  input  wire logic                  instr_valid_i,
  input  wire logic [31:0]           instr_i,
  // architecture state
  input  wire logic                  rev_newest_i,
  input  wire logic                  rev_first_i,
  input  wire logic                  cp0_enabled_i,
  input  wire logic                  ops64_enabled_i,
  input  wire logic [31:0]           hw_read_enable_mask_i,
  // hardware values
  input  wire logic [31:0]           exception_base_reg_i,
  input  wire logic [31:0]           cache_sync_step_i,
  input  wire logic [31:0]           cycle_count_view_i,
  input  wire logic [31:0]           cycle_count_resolution_i,
  input  wire logic [XLEN*2*PERF_PAIRS-1:0] perf_counter_pair_i,
  input  wire logic                  perf_is_64_i,
  input  wire logic                  paired_atomic_absent_i,
  input  wire logic                  thread_ptr_impl_i,
  input  wire logic [XLEN-1:0]       thread_pointer_reg_i,
  input  wire logic                  impl_a_present_i,
  input  wire logic                  impl_b_present_i,
  input  wire logic [XLEN-1:0]       impl_a_value_i,
  input  wire logic [XLEN-1:0]       impl_b_value_i,
  // result
  output logic                       gpr_we_o,
  output logic [4:0]                 gpr_addr_o,
  output logic [XLEN-1:0]            gpr_data_o,
  output logic                       rsvd_exc_o,
  // register port
  input  wire logic [31:0]           reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic [31:0]                reg_rdata_o,
  output logic                       irq_o
);
  import uhr_pkg::*;

  uhr_fields_if fld ();

  uhr_field_dec u_dec (
    .instr_i (instr_i),
    .fld     (fld)
  );

  typedef enum logic [2:0] {
    UHR_IDLE = 3'b001,
    UHR_DONE = 3'b010,
    UHR_TRAP = 3'b100
  } uhr_state_type;

  uhr_state_type          state_r;
  uhr_state_type          state_nxt;
  logic                   permit;
  logic                   implemented;
  logic [XLEN-1:0]        value;
  logic                   do_op;
  logic [EV_W-1:0]        isr_r;
  logic [EV_W-1:0]        imr_r;
  logic [2:0]             perf_idx;
  logic [XLEN-1:0]        perf_word;

  function automatic logic [XLEN-1:0] sext32(input logic [31:0] v);
    sext32 = {{(XLEN-32){v[31]}}, v};
  endfunction

  // wide values keep all bits only with 64-bit ops enabled
  function automatic logic [XLEN-1:0] sext_if32(input logic [XLEN-1:0] v,
                                                 input logic         wide,
                                                 input logic         en64);
    if (wide && en64) begin
      sext_if32 = v;
    end else begin
      sext_if32 = sext32(v[31:0]);
    end
  endfunction

  assign do_op    = instr_valid_i && fld.is_op;
  assign perf_idx = fld.sel;
  assign perf_word = perf_counter_pair_i[perf_idx*XLEN +: XLEN];

  assign permit = cp0_enabled_i || hw_read_enable_mask_i[fld.rnum];

  // value select and implementation check
  always_comb begin
    value       = RESET_DATA;
    implemented = 1'b0;
    if (fld.rnum == HWR_PERF) begin
      // select indexes control/counter pairs on newest revision only
      implemented = rev_newest_i && ({1'b0, fld.sel} < 4'(2*PERF_PAIRS));
      value       = sext_if32(perf_word, perf_is_64_i, ops64_enabled_i);
    end else if (fld.sel == SEL_LEGACY) begin
      unique case (fld.rnum)
        HWR_CPU_INDEX: begin
          implemented = 1'b1;
          value = sext32({22'h0, exception_base_reg_i[CPU_INDEX_W-1:0]});
        end
        HWR_SYNC_STEP: begin
          implemented = 1'b1;
          value = sext32(cache_sync_step_i);
        end
        HWR_CYCLE_COUNT: begin
          implemented = 1'b1;
          value = sext32(cycle_count_view_i);
        end
        HWR_CC_RES: begin
          implemented = 1'b1;
          value = sext32(cycle_count_resolution_i);
        end
        HWR_PAIRED_ATOM: begin
          implemented = rev_newest_i;
          value = {63'h0, paired_atomic_absent_i};
        end
        HWR_THREAD_PTR: begin
          implemented = thread_ptr_impl_i;
          value = sext_if32(thread_pointer_reg_i, 1'b1, ops64_enabled_i);
        end
        HWR_IMPL_A: begin
          implemented = impl_a_present_i;
          value = sext_if32(impl_a_value_i, 1'b1, ops64_enabled_i);
        end
        HWR_IMPL_B: begin
          implemented = impl_b_present_i;
          value = sext_if32(impl_b_value_i, 1'b1, ops64_enabled_i);
        end
        default: begin
          implemented = 1'b0;
          value = RESET_DATA;
        end
      endcase
    end else begin
      // nonzero select on a single-instance register
      implemented = !rev_newest_i;
      unique case (fld.rnum)
        HWR_CPU_INDEX, HWR_SYNC_STEP, HWR_CYCLE_COUNT, HWR_CC_RES: begin
          value = RESET_DATA;
        end
        default: begin
          implemented = 1'b0;
          value = RESET_DATA;
        end
      endcase
      implemented = 1'b0;
    end
  end

  // outcome of the current issue slot
  always_comb begin
    state_nxt = UHR_IDLE;
    if (do_op) begin
      if (rev_first_i || !permit || !implemented) begin
        state_nxt = UHR_TRAP;
      end else begin
        state_nxt = UHR_DONE;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r <= UHR_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // write-back port, one cycle after issue
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      gpr_we_o   <= 1'b0;
      gpr_addr_o <= 5'h00;
      gpr_data_o <= RESET_DATA;
    end else begin
      gpr_we_o   <= (state_nxt == UHR_DONE);
      if (state_nxt == UHR_DONE) begin
        gpr_addr_o <= fld.dest;
        gpr_data_o <= value;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rsvd_exc_o <= 1'b0;
    end else begin
      rsvd_exc_o <= (state_nxt == UHR_TRAP);
    end
  end

  // sticky event status, read clears, set beats clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      isr_r <= '0;
    end else begin
      isr_r <= ((reg_rd_i && reg_addr_i == ISR_OFF) ? '0 : isr_r)
             | {state_nxt == UHR_TRAP, state_nxt == UHR_DONE};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      imr_r <= '0;
    end else if (reg_wr_i && reg_addr_i == IMR_OFF) begin
      imr_r <= reg_wdata_i[EV_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        ISR_OFF: reg_rdata_o <= {30'h0, isr_r};
        IMR_OFF: reg_rdata_o <= {30'h0, imr_r};
        default: reg_rdata_o <= 32'h0;
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(isr_r & imr_r);
    end
  end

endmodule // uhr_read_hw
`default_nettype wire

//--- test/test_user_hw_register_read.sv
// Purpose: random self-checking run of the hardware register read
// Assumes: word driven each cycle, result checked one cycle later
// Notes:   status and mask reached over the register port
`timescale 1ns/10ps
`default_nettype none
module test_user_hw_register_read;
  import uhr_pkg::*;
  logic sys_clk_i = 0, rst_i = 1, instr_valid_i = 0, rev_newest_i = 0, rev_first_i = 0;
  logic cp0_enabled_i = 0, ops64_enabled_i = 0, perf_is_64_i = 0, paired_atomic_absent_i = 0;
  logic thread_ptr_impl_i = 0, impl_a_present_i = 0, impl_b_present_i = 0;
  logic reg_wr_i = 0, reg_rd_i = 0, gpr_we_o, rsvd_exc_o, irq_o;
  logic [31:0] instr_i = 0, hw_read_enable_mask_i = 0, exception_base_reg_i = 0;
  logic [31:0] cache_sync_step_i = 0, reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
  logic [31:0] cycle_count_view_i, cycle_count_resolution_i;
  logic [XLEN*2*PERF_PAIRS-1:0] perf_counter_pair_i = '0;
  logic [63:0] thread_pointer_reg_i = 0, impl_a_value_i = 0, impl_b_value_i = 0, gpr_data_o;
  logic [4:0] gpr_addr_o;
  logic [1:0] st, mk;
  integer seed = 49354, error_cnt = 0, n_checks = 0, i;
  uhr_read_hw i_dut (.*);
  uhr_cp0_model #(.RES(3)) i_cp0 (.sys_clk_i, .rst_i,
    .cycle_count_view_o(cycle_count_view_i), .cycle_count_resolution_o(cycle_count_resolution_i));
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic [63:0] sx(input logic [31:0] a);
    return {{32{a[31]}}, a};
  endfunction
  function automatic logic [63:0] w64(input logic [63:0] a);
    return ops64_enabled_i ? a : sx(a[31:0]);
  endfunction
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1;
    @(posedge sys_clk_i);
    reg_wr_i <= 0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1;
    @(posedge sys_clk_i);
    reg_rd_i <= 0;
    @(negedge sys_clk_i);
    chk("rdata", e, reg_rdata_o);
  endtask
  task automatic run(input int n);
    logic [31:0] w;
    logic [63:0] v, x, pv;
    logic [4:0] r, pd;
    logic t, o, pt, po;
    po = 0;
    for (int k = 0; k <= n; k++) begin
      @(posedge sys_clk_i);
      w = {6'h1f, 5'h0, 5'($random(seed)), 5'($random(seed)), 5'h0, 6'h3b};
      if ($random(seed) & 1) w[14:13] = {2{w[15]}};
      if ($random(seed) % 4 == 0) w[15:6] = {5'h4, 2'h0, 3'($random(seed))};
      else if ($random(seed) % 8 == 0) w[8:6] = 3'($random(seed));
      if ($random(seed) % 8 == 0) w = w ^ (32'h1 << 5'($random(seed)));
      instr_i <= w;
      instr_valid_i <= k < n && $random(seed) % 4 != 0;
      rev_first_i <= $random(seed) % 8 == 0;
      rev_newest_i <= $random(seed) % 4 != 0;
      {cp0_enabled_i, ops64_enabled_i, perf_is_64_i, paired_atomic_absent_i, thread_ptr_impl_i,
        impl_a_present_i, impl_b_present_i} <= 7'($random(seed));
      hw_read_enable_mask_i <= $random(seed);
      exception_base_reg_i <= $random(seed) & 32'hfffffdff;
      cache_sync_step_i <= $random(seed);
      for (int j = 0; j < 16; j++) perf_counter_pair_i[j*32+:32] <= $random(seed);
      thread_pointer_reg_i <= {$random(seed), $random(seed)};
      impl_a_value_i <= {$random(seed), $random(seed)};
      impl_b_value_i <= {$random(seed), $random(seed)};
      @(negedge sys_clk_i);
      chk("we", po && !pt, gpr_we_o);
      chk("exc", po && pt, rsvd_exc_o);
      if (po && !pt) chk("addr", pd, gpr_addr_o);
      if (po && !pt) chk("data", pv, gpr_data_o);
      if (po) st = st | (pt ? 2'h2 : 2'h1);
      o = instr_valid_i && instr_i[31:21] == 11'h3e0 && instr_i[10:9] == 0
        && instr_i[5:0] == 6'h3b;
      r = instr_i[15:11];
      t = rev_first_i || !(cp0_enabled_i || hw_read_enable_mask_i[r])
        || (instr_i[8:6] != 0 && r != 4);
      case (r)
        0: v = {54'h0, exception_base_reg_i[9:0]};
        1: v = sx(cache_sync_step_i);
        2: v = sx(cycle_count_view_i);
        3: v = sx(cycle_count_resolution_i);
        4: begin
          t = t || !rev_newest_i;
          x = perf_counter_pair_i[instr_i[8:6]*64+:64];
          v = perf_is_64_i ? w64(x) : sx(x[31:0]);
        end
        5: begin
          t = t || !rev_newest_i;
          v = {63'h0, paired_atomic_absent_i};
        end
        29: {t, v} = {t || !thread_ptr_impl_i, w64(thread_pointer_reg_i)};
        30: {t, v} = {t || !impl_a_present_i, w64(impl_a_value_i)};
        31: {t, v} = {t || !impl_b_present_i, w64(impl_b_value_i)};
        default: t = 1;
      endcase
      {po, pt, pd, pv} = {o, t, instr_i[20:16], v};
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #(25 * 8000);
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 0;
    rd(ISR_OFF, 0);
    rd(IMR_OFF, 0);
    for (i = 0; i < 6; i++) begin
      mk = 2'($random(seed));
      wr(IMR_OFF, {30'h0, mk});
      wr(32'h10, 32'hffffffff);
      rd(IMR_OFF, {30'h0, mk});
      st = 0;
      run(300);
      repeat (2) @(negedge sys_clk_i);
      chk("irq", |(st & mk), irq_o);
      rd(ISR_OFF, {30'h0, st});
      rd(ISR_OFF, 0);
      rd(32'h8, 0);
      chk("irq", 0, irq_o);
      $display("test %0d done", i);
    end
    tally_and_finish;
  end
endmodule // test_user_hw_register_read
bind uhr_read_hw uhr_read_hw_chk i_chk (.*);
`default_nettype wire

//--- test/uhr_cp0_model.sv
// Purpose: cp0 cycle counter beside the read block
// Assumes: counter steps once every RES core cycles
// Notes:   starts just below the sign bit so reads cross it
`timescale 1ns/10ps
`default_nettype none
module uhr_cp0_model #(parameter int RES = 3) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  output logic [31:0]      cycle_count_view_o,
  output logic [31:0]      cycle_count_resolution_o
);
  int div_r;
  assign cycle_count_resolution_o = 32'(RES);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || div_r == RES - 1) div_r <= 0;
    else div_r <= div_r + 1;
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) cycle_count_view_o <= 32'h7ffffe00;
    else if (div_r == RES - 1) cycle_count_view_o <= cycle_count_view_o + 32'h1;
  end
endmodule // uhr_cp0_model
`default_nettype wire

//--- test/uhr_read_hw_chk.sv
// Purpose: port assertions of the hardware register read
// Assumes: answer one cycle after a taken word
// Notes:   bound to uhr_read_hw from the bench top
`timescale 1ns/10ps
`default_nettype none
module uhr_read_hw_chk
  import uhr_pkg::*;
(
  // clock, reset and issue
  input wire logic        sys_clk_i, rst_i, instr_valid_i, rev_first_i, cp0_enabled_i,
  input wire logic [31:0] instr_i, hw_read_enable_mask_i, cycle_count_view_i,
  // results
  input wire logic        gpr_we_o, rsvd_exc_o, irq_o,
  input wire logic [4:0]  gpr_addr_o,
  input wire logic [63:0] gpr_data_o
);
  wire logic [4:0] rn = instr_i[RNUM_HI:RNUM_LO];
  wire logic hit = instr_valid_i && instr_i[OPC_HI:OPC_LO] == SPECIAL_THREE_OPCODE
    && instr_i[ZERO_A_HI:ZERO_A_LO] == 5'h0 && instr_i[ZERO_B_HI:ZERO_B_LO] == 2'h0
    && instr_i[FUNC_HI:FUNC_LO] == READ_HW_FUNC;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  AST_ANSWER: assert property (hit |=> gpr_we_o != rsvd_exc_o)
    else $error("taken word without one answer");
  AST_IGNORE: assert property (!hit |=> !gpr_we_o && !rsvd_exc_o)
    else $error("answer without taken word");
  AST_FIRST: assert property (hit && rev_first_i |=> rsvd_exc_o)
    else $error("first revision did not trap");
  AST_GATE: assert property (hit && !cp0_enabled_i && !hw_read_enable_mask_i[rn]
    |=> rsvd_exc_o)
    else $error("read not permitted but done");
  AST_RESV: assert property (hit && rn inside {[6:28]} |=> rsvd_exc_o)
    else $error("reserved number did not trap");
  AST_SEL: assert property (hit && instr_i[SEL_HI:SEL_LO] != SEL_LEGACY && rn != HWR_PERF
    |=> rsvd_exc_o)
    else $error("undefined select did not trap");
  AST_DEST: assert property (hit ##1 gpr_we_o
    |-> gpr_addr_o == $past(instr_i[DEST_HI:DEST_LO]))
    else $error("wrong destination");
  AST_COUNT: assert property (hit && rn == HWR_CYCLE_COUNT ##1 gpr_we_o |-> gpr_data_o ==
    {{32{$past(cycle_count_view_i[31])}}, $past(cycle_count_view_i)})
    else $error("cycle count value wrong");
  AST_HOLD: assert property (rsvd_exc_o |-> !gpr_we_o && $stable(gpr_data_o))
    else $error("trap touched the gpr");
  cover property (gpr_we_o);
  cover property (rsvd_exc_o);
  cover property (irq_o);
endmodule // uhr_read_hw_chk
`default_nettype wire
